// ---- hdl/rtcwec_regs.vh ----
/*
 * Register offsets, field positions, reset values and timing constants of the
 * watch error correction block.
 * Assumes inclusion by the block's design file, its checker and its bench.
 */
`ifndef RTCWEC_REGS_VH
`define RTCWEC_REGS_VH

// ==========================================================================
// Register map (byte addresses on the AXI4-Lite bus)
`define RTCWEC_ADDR_CORR        4'h0
`define RTCWEC_ADDR_STATUS      4'h4
`define RTCWEC_ADDR_CTRL        4'h8
`define RTCWEC_ADDR_SUBCNT      4'hc

// ==========================================================================
// Fields of the correction register
`define RTCWEC_CORR_RESET       8'h00
`define RTCWEC_RES_SEL_BIT      7
`define RTCWEC_SIGN_BIT         6
`define RTCWEC_MAG_MSB          5

// ==========================================================================
// Control register: bit 0 enables counting
`define RTCWEC_CTRL_RESET       1'b0

// ==========================================================================
// Timing: the sub-count clock is an enable derived from aclk
`define RTCWEC_ACLK_HZ          250000000
`define RTCWEC_SUB_HZ           32768
`define RTCWEC_SUB_DIV          (`RTCWEC_ACLK_HZ / `RTCWEC_SUB_HZ)
`define RTCWEC_SUB_DIV_LAST     13'd7628
`define RTCWEC_SEC_COUNTS       16'h8000
`define RTCWEC_SECS_PER_MIN     6'h3c
`define RTCWEC_COARSE_STEP_SEC  6'h14
`define RTCWEC_COARSE_PT2       6'h28

// Bus responses
`define RTCWEC_RESP_OKAY        2'b00
`define RTCWEC_RESP_SLVERR      2'b10

`endif

// ---- hdl/rtcwec_top.v ----
/*
 * Watch error correction for the real-time counter: an AXI4-Lite register
 * file, a sub-count of nominal 32768 counts per second and the digital
 * correction that lengthens or shortens chosen seconds.
 * Assumes a single 250 MHz aclk with synchronous active-low reset; the
 * 32768 Hz tick is a one-cycle enable from an internal divider.
 * Counting stops while the control enable is clear; the counter then waits at
 * the top of second 00 with that second's corrected length already loaded, so
 * software can read back what a value will do before starting the count.
 */
//
// Contract
// RL1: Rate is corrected by lengthening or shortening the sub-count, never by touching the oscillator.
// RL2: The correction range covers a frequency error from -189 ppm to +189 ppm.
// RL3: One magnitude step is worth 3.05 ppm in coarse mode and 1.02 ppm in fine mode.
// RL4: In coarse mode the total correction per minute is three times the encoded value.
// RL5: In fine mode the total correction per minute equals the encoded value against 32768-count seconds.
// RL6: Sign clear delays the clock by adding (magnitude - 1) * 2 counts.
// RL7: Sign set speeds the clock by removing (~magnitude + 1) * 2 counts.
// RL8: Software picks coarse mode when the needed correction is 63.1 ppm or more in size.
// RL9: Software derives a new value from the last temperature reading and writes it to retune the rate.
// RL10: A zero magnitude field performs no correction whatever the sign.
// RL11: The correction register resets to zero, leaving the counter uncorrected.
// RL12: Coarse correction is applied at seconds 00, 20 and 40.
// RL13: A new value takes effect at the next correction point; a running correction is not altered.
`timescale 1ns/100ps
`include "rtcwec_regs.vh"

module rtcwec_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         one_hertz_tick,
	output reg         sub_tick
);

	// ======================================================================
	// Register file
	reg  [7:0]  watch_error_correction_q;
	reg         count_en_q;
	reg  [15:0] sub_count_q;
	reg  [5:0]  sec_q;
	reg  [7:0]  applied_q;
	reg  [15:0] sec_len_q;

	// ======================================================================
	// AXI4-Lite write channel: address and data taken in either order
	reg         aw_held_q;
	reg  [3:0]  aw_addr_q;
	reg         w_held_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	wire        wr_fire;

	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RTCWEC_RESP_OKAY;
			aw_held_q     <= 1'b0;
			aw_addr_q     <= 4'h0;
			w_held_q      <= 1'b0;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
		end else begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RTCWEC_RESP_OKAY;
				case (aw_addr_q)
				`RTCWEC_ADDR_CORR, `RTCWEC_ADDR_CTRL, `RTCWEC_ADDR_STATUS, `RTCWEC_ADDR_SUBCNT: begin
					// All four mapped words answer OKAY; the read-only ones ignore the data
					s_axi_bresp <= `RTCWEC_RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `RTCWEC_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Register updates; only the low byte lane carries writable bits
	wire        corr_wr;
	wire        ctrl_wr;

	assign corr_wr = wr_fire && (aw_addr_q == `RTCWEC_ADDR_CORR) && w_strb_q[0];
	assign ctrl_wr = wr_fire && (aw_addr_q == `RTCWEC_ADDR_CTRL) && w_strb_q[0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			watch_error_correction_q <= `RTCWEC_CORR_RESET; // [RL11]
			count_en_q               <= `RTCWEC_CTRL_RESET;
		end else begin
			if (corr_wr) begin
				// Only stored here; the counter picks it up when a second starts
				watch_error_correction_q <= w_data_q[7:0]; // [RL13]
			end
			if (ctrl_wr) begin
				count_en_q <= w_data_q[0];
			end
		end
	end

	// ======================================================================
	// AXI4-Lite read channel
	reg  [31:0] rd_word;
	reg  [1:0]  rd_resp;

	always @* begin
		rd_word = 32'h0000_0000;
		rd_resp = `RTCWEC_RESP_OKAY;
		case (s_axi_araddr)
		`RTCWEC_ADDR_CORR: begin
			rd_word = {24'h00_0000, watch_error_correction_q};
		end
		`RTCWEC_ADDR_STATUS: begin
			rd_word = {10'h000, sec_len_q, sec_q};
		end
		`RTCWEC_ADDR_CTRL: begin
			rd_word = {31'h0000_0000, count_en_q};
		end
		`RTCWEC_ADDR_SUBCNT: begin
			rd_word = {8'h00, applied_q, sub_count_q};
		end
		default: begin
			rd_resp = `RTCWEC_RESP_SLVERR;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RTCWEC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= rd_resp;
				s_axi_rdata  <= rd_word;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// 32768 Hz enable from aclk; fractional error is irrelevant to the
	// correction logic, which counts ticks only
	localparam [12:0] DIV_LAST = `RTCWEC_SUB_DIV_LAST;
	reg  [12:0] div_q;
	wire        tick;

	assign tick = count_en_q && (div_q == DIV_LAST);

	always @(posedge aclk) begin
		if (!aresetn || !count_en_q)
			div_q <= 13'h0000;
		else if (tick)
			div_q <= 13'h0000;
		else
			div_q <= div_q + 13'h0001;
	end

	// ======================================================================
	// Correction decode from the register value
	wire [5:0]  mag;
	wire        neg;
	wire        fine;
	reg  [6:0]  corr_abs;
	reg  [5:0]  sec_next;
	reg         at_point;
	reg  [15:0] next_len;
	reg  [7:0]  next_applied;

	assign mag  = watch_error_correction_q[`RTCWEC_MAG_MSB:0];
	assign neg  = watch_error_correction_q[`RTCWEC_SIGN_BIT];
	assign fine = watch_error_correction_q[`RTCWEC_RES_SEL_BIT];

	// Up to 124 counts added or 126 removed a point: 3.05 ppm steps coarse, 1.02 ppm fine  [RL2] [RL3]
	always @* begin
		if (neg) begin
			corr_abs = {(~mag) + 6'h01, 1'b0}; // [RL7]
		end else begin
			corr_abs = {mag - 6'h01, 1'b0}; // [RL6]
		end
	end

	// Index of the second about to start; a stopped counter restarts at 00
	always @* begin
		if (!count_en_q) begin
			sec_next = 6'h00;
		end else if (sec_q == `RTCWEC_SECS_PER_MIN - 6'h01) begin
			sec_next = 6'h00;
		end else begin
			sec_next = sec_q + 6'h01;
		end
	end

	// The point is judged on the second that starts, not the one that ends
	always @* begin
		at_point = 1'b0;
		if (fine) begin
			at_point = (sec_next == 6'h00); // [RL5]
		end else begin
			at_point = (sec_next == 6'h00)
				|| (sec_next == `RTCWEC_COARSE_STEP_SEC)
				|| (sec_next == `RTCWEC_COARSE_PT2); // [RL4] [RL12]
		end
	end

	// Zero magnitude leaves a plain 32768-count second whatever the sign
	always @* begin
		next_len     = `RTCWEC_SEC_COUNTS;
		next_applied = 8'h00;
		if (at_point && (mag != 6'h00)) begin // [RL10] [RL11]
			if (neg) begin
				next_len     = `RTCWEC_SEC_COUNTS - {9'h000, corr_abs}; // [RL1] [RL7]
				next_applied = 8'h00 - {1'b0, corr_abs};
			end else begin
				next_len     = `RTCWEC_SEC_COUNTS + {9'h000, corr_abs}; // [RL1] [RL6]
				next_applied = {1'b0, corr_abs};
			end
		end
	end

	// ======================================================================
	// Sub-count and seconds; a second's length is fixed at its start, so
	// a write mid-second cannot disturb it  [RL13]
	always @(posedge aclk) begin
		if (!aresetn) begin
			sub_count_q    <= 16'h0000;
			sec_q          <= 6'h00;
			sec_len_q      <= `RTCWEC_SEC_COUNTS;
			applied_q      <= 8'h00;
			one_hertz_tick <= 1'b0;
			sub_tick       <= 1'b0;
		end else if (!count_en_q) begin
			// Stopped: wait at the top of second 00 with its length preloaded
			sub_count_q    <= 16'h0000;
			sec_q          <= 6'h00;
			sec_len_q      <= next_len;
			applied_q      <= next_applied;
			one_hertz_tick <= 1'b0;
			sub_tick       <= 1'b0;
		end else begin
			one_hertz_tick <= 1'b0;
			sub_tick       <= tick;
			if (tick) begin
				if (sub_count_q == sec_len_q - 16'h0001) begin
					sub_count_q    <= 16'h0000;
					one_hertz_tick <= 1'b1;
					sec_len_q      <= next_len;
					applied_q      <= next_applied;
					sec_q          <= sec_next;
				end else begin
					sub_count_q <= sub_count_q + 16'h0001;
				end
			end
		end
	end

endmodule

// ---- test/rtcwec_assertions.sv ----
/* Checker for the bus handshakes and tick outputs of the correction block.
   Bound to the top module from the bench file. */
`timescale 1ns/100ps
`include "rtcwec_regs.vh"
module rtcwec_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        one_hertz_tick,
	input wire logic        sub_tick
);
	// ==========================================
	// Tick spacing; saturates so a long stop cannot wrap
	logic [15:0] gap_q;
	logic        seen_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			gap_q <= 16'h0000;
			seen_q <= 1'b0;
		end else if (sub_tick) begin
			gap_q <= 16'h0001;
			seen_q <= 1'b1;
		end else if (gap_q != 16'hffff) begin
			gap_q <= gap_q + 16'h0001;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	tick_gap_a: assert property (sub_tick && seen_q |-> gap_q >= `RTCWEC_SUB_DIV)
		else $error("sub tick came early");
	tick_single_a: assert property (sub_tick |=> !sub_tick [*8])
		else $error("sub tick too long");
	sec_pulse_a: assert property (one_hertz_tick |=> !one_hertz_tick)
		else $error("second pulse too long");
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready too long");
	sec_on_tick_a: assert property (one_hertz_tick |-> sub_tick)
		else $error("second pulse off a sub tick");
	cover property (one_hertz_tick);
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (sub_tick && seen_q);
endmodule

// ---- test/rtcwec_tb_top.sv ----
/* Self-checking bench: register access and sub tick rate.
   Assumes the register map header and a 4 ns aclk. */
`timescale 1ns/100ps
`include "rtcwec_regs.vh"
module rtcwec_tb_top;
	logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, bready = 0, rready = 0, done;
	logic [3:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rd;
	logic [1:0]  rs;
	wire         awready, wready, bvalid, arready, rvalid, one_hz, sub_tick;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          fail_count = 0, checks = 0, n;
	always #2 aclk = ~aclk;
	rtcwec_top u_rtcwec_top(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .one_hertz_tick(one_hz), .sub_tick(sub_tick));
	task chk(input [31:0] got, input [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ==========================================
	// Bus tasks; ready follows valid by one cycle so the hold is exercised
	task wr(input [3:0] a, input [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awv <= 1;
		wv <= 1;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
			rs = bresp;
			done = bvalid & bready;
			@(posedge aclk);
			if (awready) awv <= 0;
			if (wready) wv <= 0;
			bready <= bvalid & !done;
		end while (!done && n < 50);
		if (!done) chk(0, 1);
	endtask
	task rdr(input [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arv <= 1;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
			rs = rresp;
			rd = rdata;
			done = rvalid & rready;
			@(posedge aclk);
			if (arready) arv <= 0;
			rready <= rvalid & !done;
		end while (!done && n < 50);
		if (!done) chk(0, 1);
	endtask
	// ==========================================
	// Scenarios
	// Stopped counter shows the length and signed amount its second 00 will get
	task corr_case(input [7:0] v, input [15:0] len, input [7:0] app);
		wr(`RTCWEC_ADDR_CORR, {24'h00_0000, v});
		chk(rs, `RTCWEC_RESP_OKAY);
		rdr(`RTCWEC_ADDR_STATUS);
		chk(rd[21:6], len);
		chk(rd[5:0], 0);
		rdr(`RTCWEC_ADDR_SUBCNT);
		chk(rd[23:16], app);
	endtask
	task t_fields;
		rdr(`RTCWEC_ADDR_CORR);
		chk(rd, 0);
		rdr(`RTCWEC_ADDR_STATUS);
		chk(rd, 32'h0020_0000);
		// 131 ppm fast: coarse, (44-1)*2 = 86 counts added
		corr_case(8'h2c, 16'h8056, 8'h56);
		rdr(`RTCWEC_ADDR_CORR);
		chk(rd, 32'h2c);
		// Fine, sign set, mag 46: (17+1)*2 = 36 counts removed
		corr_case(8'hee, 16'h7fdc, 8'hdc);
		rdr(`RTCWEC_ADDR_CORR);
		chk(rd, 32'hee);
		corr_case(8'h3f, 16'h807c, 8'h7c);
		corr_case(8'h42, 16'h7f84, 8'h84);
		corr_case(8'h40, 16'h8000, 8'h00);
		corr_case(8'hc0, 16'h8000, 8'h00);
		corr_case(8'h01, 16'h8000, 8'h00);
		chk(rs, `RTCWEC_RESP_OKAY);
		wr(4'h2, 32'h000000ff);
		chk(rs, `RTCWEC_RESP_SLVERR);
		$display("test fields done");
	endtask
	task t_tick;
		wr(`RTCWEC_ADDR_CORR, 32'h0);
		wr(`RTCWEC_ADDR_CTRL, 32'h1);
		// Running second keeps the length it started with
		wr(`RTCWEC_ADDR_CORR, 32'h2c);
		rdr(`RTCWEC_ADDR_STATUS);
		chk(rd[21:6], 16'h8000);
		n = 0;
		while (!sub_tick && n < 20000) begin
			@(negedge aclk);
			n++;
		end
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!sub_tick && n < 20000);
		chk(n, `RTCWEC_SUB_DIV);
		$display("test tick done");
	endtask
	task test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#400000;
		fail_count++;
		test_done;
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		t_fields;
		t_tick;
		test_done;
	end
endmodule
bind rtcwec_top rtcwec_checker u_rtcwec_checker(.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .one_hertz_tick(one_hertz_tick), .sub_tick(sub_tick));
